//--- rtl/hall_sensor_register_map.sv
// Register map of the three-axis field sensor: user storage, control word and
// the two readout words. Assumes the serial front end presents decoded register
// accesses on a word port, all on clk_sys, and raises unlock while the user
// write unlock is active.
module hall_sensor_register_map
#(
  parameter int TICK_CYCLES = hall_regmap_pkg::INACT_TICK_CYCLES,
  parameter int PROG_CYCLES = hall_regmap_pkg::NV_PROG_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic unlock,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_r,
  output logic reg_rvalid_r,
  input wire logic sample_valid,
  input wire logic [11:0] sample_x,
  input wire logic [11:0] sample_y,
  input wire logic [11:0] sample_z,
  input wire logic [11:0] sample_temp,
  input wire logic [1:0] sample_hall,
  input wire logic int_event,
  input wire logic int_hold_en,
  input wire logic int_record_en,
  output logic int_n_r,
  output logic record_done_r,
  output logic measure_en_r,
  output logic [1:0] power_mode_r,
  output logic [1:0] loop_mode_r
);
  import hall_regmap_pkg::*;
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // Declarations
  logic [25:0] user_mem_r [3];
  logic [2:0] inact_code_r;
  logic [11:0] x_r;
  logic [11:0] y_r;
  logic [11:0] z_r;
  logic [11:0] temp_r;
  logic [1:0] hall_r;
  logic new_r;
  logic int_flag_r;
  logic int_flag_nxt;
  logic event_q_r;
  logic event_rise;
  logic accept;
  logic wr_ok;
  logic w1c;
  logic hi_read;
  logic nv_busy;
  logic nv_done;
  logic duty_measure;

  // ==========================================================================
  // Address decoding
  function automatic logic is_user(input logic [7:0] a);
    is_user = (a == OFS_USER_A) || (a == OFS_USER_B) || (a == OFS_USER_C);
  endfunction

  function automatic logic [1:0] user_index(input logic [7:0] a);
    user_index = 2'(a - OFS_USER_A);
  endfunction

  assign wr_ok = reg_wr && unlock;
  assign hi_read = reg_rd && (reg_addr == OFS_FIELD_HI);
  assign w1c = wr_ok && (reg_addr == OFS_FIELD_HI) && reg_wdata[HI_INT_BIT];
  assign accept = sample_valid && (power_mode_r != MODE_SLEEP);
  assign event_rise = int_event && !event_q_r;

  // ==========================================================================
  // User storage words
  // user storage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < 3; i++)
        user_mem_r[i] <= USER_RESET;
    end
    else if (clk_en && wr_ok && is_user(reg_addr))
    begin
      user_mem_r[user_index(reg_addr)] <= reg_wdata[USER_W-1:0];
    end
  end

  // ==========================================================================
  // Control word
  // The power-mode field is the only one that software may change while
  // locked, so that a locked host can still put the part to sleep.
  // mode always writable
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      power_mode_r <= CTRL_MODE_RESET;
    else if (clk_en && reg_wr && reg_addr == OFS_CTRL)
      power_mode_r <= reg_wdata[CTRL_MODE_LSB +: 2];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      inact_code_r <= CTRL_COUNT_RESET;
      loop_mode_r <= CTRL_LOOP_RESET;
    end
    else if (clk_en && wr_ok && reg_addr == OFS_CTRL)
    begin
      inact_code_r <= reg_wdata[CTRL_COUNT_LSB +: 3];
      loop_mode_r <= reg_wdata[CTRL_LOOP_LSB +: 2];
    end
  end

  // ==========================================================================
  // Operating state
  duty_cycle_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_duty (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .duty_mode(power_mode_r == duty_cycled_power_state),
    .inact_code(inact_code_r),
    .sample_done(accept),
    .measure_r(duty_measure)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      measure_en_r <= 1'b0;
    else if (clk_en)
    begin
      case (power_mode_r)
        MODE_ACTIVE: measure_en_r <= 1'b1;
        MODE_SLEEP: measure_en_r <= 1'b0;
        duty_cycled_power_state: measure_en_r <= duty_measure;
        default: measure_en_r <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Sample snapshot
  // Both readout words come from one snapshot; the host keeps them paired by
  // fetching them in one burst, since a sample may land between two reads.
  // paired snapshot
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      x_r <= 12'h000;
      y_r <= 12'h000;
      z_r <= 12'h000;
      temp_r <= 12'h000;
      hall_r <= HALL_SINGLE;
    end
    else if (clk_en && accept)
    begin
      x_r <= sample_x;
      y_r <= sample_y;
      z_r <= sample_z;
      temp_r <= sample_temp;
      hall_r <= sample_hall;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      new_r <= 1'b0;
    else if (clk_en)
    begin
      if (accept)
        new_r <= 1'b1;
      else if (hi_read)
        new_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt flag and output
  // flag follows event; with int_hold_en it holds until a write-one clear
  always_comb
  begin
    if (int_event)
      int_flag_nxt = 1'b1;
    else if (!int_hold_en || w1c)
      int_flag_nxt = 1'b0;
    else
      int_flag_nxt = int_flag_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      int_flag_r <= 1'b0;
      int_n_r <= 1'b1;
      event_q_r <= 1'b0;
    end
    else if (clk_en)
    begin
      int_flag_r <= int_flag_nxt;
      int_n_r <= !int_flag_nxt;
      event_q_r <= int_event;
    end
  end

  // ==========================================================================
  // Interrupt record programming
  // record write busy
  nv_record_writer #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_nv (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .start(event_rise && int_record_en),
    .busy_r(nv_busy),
    .done_r(nv_done)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      record_done_r <= 1'b0;
    else if (clk_en)
      record_done_r <= nv_done;
  end

  // ==========================================================================
  // Read port
  // reads never locked
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata_r <= 32'h00000000;
      reg_rvalid_r <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata_r <= 32'h00000000;
        if (is_user(reg_addr))
          reg_rdata_r[USER_W-1:0] <= user_mem_r[user_index(reg_addr)];
        else if (reg_addr == OFS_CTRL)
        begin
          reg_rdata_r[CTRL_COUNT_LSB +: 3] <= inact_code_r;
          reg_rdata_r[CTRL_LOOP_LSB +: 2] <= loop_mode_r;
          reg_rdata_r[CTRL_MODE_LSB +: 2] <= power_mode_r;
        end
        else if (reg_addr == OFS_FIELD_HI)
        begin
          reg_rdata_r[HI_X_LSB +: 8] <= x_r[11:4];
          reg_rdata_r[HI_Y_LSB +: 8] <= y_r[11:4];
          reg_rdata_r[HI_Z_LSB +: 8] <= z_r[11:4];
          reg_rdata_r[HI_NEW_BIT] <= new_r;
          reg_rdata_r[HI_INT_BIT] <= int_flag_r;
          reg_rdata_r[HI_TEMP_LSB +: 6] <= temp_r[11:6];
        end
        else if (reg_addr == OFS_FIELD_LO)
        begin
          reg_rdata_r[LO_BUSY_BIT] <= nv_busy;
          reg_rdata_r[LO_X_LSB +: 4] <= x_r[3:0];
          reg_rdata_r[LO_Y_LSB +: 4] <= y_r[3:0];
          reg_rdata_r[LO_Z_LSB +: 4] <= z_r[3:0];
          reg_rdata_r[LO_HALL_LSB +: 2] <= hall_r;
          reg_rdata_r[LO_TEMP_LSB +: 6] <= temp_r[5:0];
        end
      end
    end
  end

  // ==========================================================================
  // Checks

  read_answer_a: assert property (
    reg_rd && clk_en |=> reg_rvalid_r)
    else $error("read not answered next cycle");

  user_lock_a: assert property (
    reg_wr && !unlock && clk_en && reg_addr == OFS_USER_A |=> $stable(user_mem_r[0]))
    else $error("locked write changed user word");

  mode_write_a: assert property (
    reg_wr && clk_en && reg_addr == OFS_CTRL
    |=> power_mode_r == $past(reg_wdata[1:0]))
    else $error("power mode write not taken");

  fresh_set_a: assert property (
    accept && clk_en |=> new_r)
    else $error("fresh flag not set by sample");

  fresh_clear_a: assert property (
    hi_read && !accept && clk_en |=> !new_r && reg_rvalid_r)
    else $error("fresh flag not cleared by read");

  hold_flag_a: assert property (
    int_hold_en && int_flag_r && !int_event && !w1c && clk_en |=> int_flag_r && !int_n_r)
    else $error("held interrupt dropped");

  clear_one_a: assert property (
    int_hold_en && w1c && !int_event && clk_en |=> !int_flag_r && int_n_r)
    else $error("write one did not clear held interrupt");

  sleep_freeze_a: assert property (
    power_mode_r == MODE_SLEEP && clk_en |=> $stable(x_r) && $stable(temp_r))
    else $error("readout changed while asleep");

  busy_start_a: assert property (
    event_rise && int_record_en && !nv_busy && clk_en |=> nv_busy)
    else $error("record busy not raised");

  hi_layout_a: assert property (
    hi_read && clk_en |=> reg_rdata_r[31:24] == $past(x_r[11:4]))
    else $error("upper X byte misplaced");

  lo_reserved_a: assert property (
    reg_rd && reg_addr == OFS_FIELD_LO && clk_en |=> reg_rdata_r[31:21] == 11'h000)
    else $error("reserved bits not zero");

  sleep_idle_a: assert property (
    power_mode_r == MODE_SLEEP && clk_en |=> !measure_en_r)
    else $error("measuring while asleep");

  cover_sample_read_c: cover property (accept ##[1:20] hi_read);
  cover_held_clear_c: cover property (int_flag_r && int_hold_en ##[1:50] w1c);
  cover_record_c: cover property (nv_busy ##1 !nv_busy);
  cover_duty_c: cover property (power_mode_r == duty_cycled_power_state && measure_en_r);

endmodule

//--- rtl/hall_regmap_pkg.sv
// Register map constants for the three-axis field sensor readout block.
// Assumes a 25 MHz system clock and a register port fed by the serial front end.
package hall_regmap_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  // One inactive tick is 0.5 ms; every inactive duration is a whole number of ticks.
  localparam int INACT_TICK_NS = 500000;
  localparam int INACT_TICK_CYCLES = INACT_TICK_NS / CLK_PERIOD_NS;
  // Inactive durations 0.5, 1, 5, 10, 50, 100, 500 and 1000 ms counted in ticks.
  localparam logic [11:0] INACT_TICKS [8] = '{12'h001, 12'h002, 12'h00A, 12'h014,
                                               12'h064, 12'h0C8, 12'h3E8, 12'h7D0};
  // Nonvolatile record programming time, a plain default of 100 us.
  localparam int NV_PROG_NS = 100000;
  localparam int NV_PROG_CYCLES = NV_PROG_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Offsets
  localparam logic [7:0] OFS_USER_A = 8'h0D;
  localparam logic [7:0] OFS_USER_B = 8'h0E;
  localparam logic [7:0] OFS_USER_C = 8'h0F;
  localparam logic [7:0] OFS_CTRL = 8'h27;
  localparam logic [7:0] OFS_FIELD_HI = 8'h28;
  localparam logic [7:0] OFS_FIELD_LO = 8'h29;

  // ==========================================================================
  // Fields and reset values
  localparam int USER_W = 26;
  localparam logic [25:0] USER_RESET = 26'h0000000;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LOOP_LSB = 2;
  localparam int CTRL_COUNT_LSB = 4;
  localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
  localparam logic [1:0] CTRL_LOOP_RESET = 2'h0;
  localparam logic [2:0] CTRL_COUNT_RESET = 3'h0;
  localparam int HI_X_LSB = 24;
  localparam int HI_Y_LSB = 16;
  localparam int HI_Z_LSB = 8;
  localparam int HI_NEW_BIT = 7;
  localparam int HI_INT_BIT = 6;
  localparam int HI_TEMP_LSB = 0;
  localparam int LO_BUSY_BIT = 20;
  localparam int LO_X_LSB = 16;
  localparam int LO_Y_LSB = 12;
  localparam int LO_Z_LSB = 8;
  localparam int LO_HALL_LSB = 6;
  localparam int LO_TEMP_LSB = 0;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] duty_cycled_power_state = 2'h2;
  localparam logic [1:0] HALL_SINGLE = 2'h0;
  localparam logic [1:0] HALL_DIFF = 2'h1;
  localparam logic [1:0] HALL_COMMON = 2'h2;

endpackage

//--- rtl/nv_record_writer.sv
// Timer that stands for the nonvolatile programming of the interrupt record bit.
// Assumes start is a one-cycle pulse from logic on clk_sys.
module nv_record_writer
#(
  parameter int PROG_CYCLES = hall_regmap_pkg::NV_PROG_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic start,
  output logic busy_r,
  output logic done_r
);
  import hall_regmap_pkg::*;

  if (PROG_CYCLES < 1 || PROG_CYCLES > 65535)
    $error("PROG_CYCLES out of range");

  logic [15:0] cnt_r;

  // ==========================================================================
  // Programming sequence
  // self clearing busy
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 16'h0000;
    end
    else if (clk_en)
    begin
      done_r <= 1'b0;
      if (busy_r)
      begin
        if (cnt_r == 16'(PROG_CYCLES - 1))
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r + 16'h0001;
      end
      else if (start)
      begin
        busy_r <= 1'b1;
        cnt_r <= 16'h0000;
      end
    end
  end

  busy_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    busy_r && clk_en && cnt_r == 16'(PROG_CYCLES - 1) |=> !busy_r && done_r)
    else $error("busy did not clear after programming time");

endmodule

//--- rtl/duty_cycle_timer.sv
// Active and inactive phase sequencer for duty-cycled low-power operation.
// Assumes sample_done pulses once when the front end finishes a measurement.
module duty_cycle_timer
#(
  parameter int TICK_CYCLES = hall_regmap_pkg::INACT_TICK_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic duty_mode,
  input wire logic [2:0] inact_code,
  input wire logic sample_done,
  output logic measure_r
);
  import hall_regmap_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
    $error("TICK_CYCLES out of range");

  typedef enum logic {DC_MEASURE, DC_INACTIVE} duty_state_e;

  duty_state_e state_r;
  logic [15:0] tick_r;
  logic [11:0] unit_r;
  logic unit_end;

  assign unit_end = (tick_r == 16'(TICK_CYCLES - 1))
                    && (unit_r == INACT_TICKS[inact_code] - 12'h001);

  // ==========================================================================
  // Phase sequencing
  // inactive durations
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= DC_MEASURE;
      tick_r <= 16'h0000;
      unit_r <= 12'h000;
    end
    else if (clk_en)
    begin
      case (state_r)
        DC_MEASURE:
        begin
          tick_r <= 16'h0000;
          unit_r <= 12'h000;
          if (duty_mode && sample_done)
            state_r <= DC_INACTIVE;
        end
        DC_INACTIVE:
        begin
          if (!duty_mode || unit_end)
            state_r <= DC_MEASURE;
          if (tick_r == 16'(TICK_CYCLES - 1))
          begin
            tick_r <= 16'h0000;
            unit_r <= unit_r + 12'h001;
          end
          else
            tick_r <= tick_r + 16'h0001;
        end
        default: state_r <= DC_MEASURE;
      endcase
    end
  end

  assign measure_r = (state_r == DC_MEASURE);

  wake_time_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == DC_INACTIVE && clk_en && duty_mode && !unit_end |=> state_r == DC_INACTIVE)
    else $error("inactive phase ended early");

endmodule

//--- testbench/reg_host_model.sv
// Host side of the register port: word writes, word reads and the paired readout fetch.
// Assumes the block takes requests on the rising edge of clk_sys and answers reads one
// cycle later.
module reg_host_model
(
  input wire logic clk_sys,
  output logic unlock,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_r,
  input wire logic reg_rvalid_r
);
  timeunit 1ns;
  timeprecision 1ns;
  import hall_regmap_pkg::*;

  initial
  begin
    unlock = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
  end

  // ==========================================================================
  // Access tasks
  // unlock framing: unlock is raised only for the write that asks for it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ul);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    unlock = ul;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    unlock = 1'b0;
    // Released data is inverted so a stale value can never look valid.
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = (reg_rvalid_r === 1'b1) ? reg_rdata_r : 32'hX;
  endtask

  // paired fetch: both readout words in back-to-back reads of one sample.
  task automatic rd_pair(output logic [31:0] hi, output logic [31:0] lo);
    @(negedge clk_sys);
    reg_addr = OFS_FIELD_HI;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_addr = OFS_FIELD_LO;
    hi = (reg_rvalid_r === 1'b1) ? reg_rdata_r : 32'hX;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    lo = (reg_rvalid_r === 1'b1) ? reg_rdata_r : 32'hX;
  endtask
endmodule

//--- testbench/hall_sensor_register_map_bench.sv
// Self-checking bench for the sensor register map.
// Assumes the host model drives the register port; the bench plays the front end.
module hall_sensor_register_map_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import hall_regmap_pkg::*;
  localparam int TICKS = 4;
  localparam int PROG = 8;
  logic clk_sys, rst, unlock, reg_wr, reg_rd, reg_rvalid_r, sample_valid;
  logic int_event, int_hold_en, int_record_en, int_n_r, record_done_r, measure_en_r;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_r, d, hi, lo;
  logic [11:0] sample_x, sample_y, sample_z, sample_temp;
  logic [1:0] sample_hall, power_mode_r, loop_mode_r;
  logic [7:0] ofs [7] = '{OFS_USER_A, OFS_USER_B, OFS_USER_C, OFS_CTRL, OFS_FIELD_HI,
                          OFS_FIELD_LO, 8'h10};
  int fail_count = 0;
  int n_compared = 0;
  int n;
  int e;

  hall_sensor_register_map #(.TICK_CYCLES(TICKS), .PROG_CYCLES(PROG)) hall_sensor_register_map_i
  (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .unlock(unlock), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z), .sample_temp(sample_temp),
    .sample_hall(sample_hall), .int_event(int_event), .int_hold_en(int_hold_en),
    .int_record_en(int_record_en), .int_n_r(int_n_r), .record_done_r(record_done_r),
    .measure_en_r(measure_en_r), .power_mode_r(power_mode_r), .loop_mode_r(loop_mode_r)
  );

  reg_host_model reg_host_model_i
  (
    .clk_sys(clk_sys), .unlock(unlock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r)
  );

  // ==========================================================================
  // Helpers
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic [31:0] hi_exp(input logic [11:0] x, input logic [11:0] t,
                                         input logic nw);
    logic [11:0] y;
    y = x ^ 12'h5A5;
    return {x[11:4], y[11:4], ~x[11:4], nw, 1'b0, t[11:6]};
  endfunction

  function automatic logic [31:0] lo_exp(input logic [11:0] x, input logic [11:0] t,
                                         input logic [1:0] h);
    logic [11:0] y;
    y = x ^ 12'h5A5;
    return {12'h000, x[3:0], y[3:0], ~x[3:0], h, t[5:0]};
  endfunction

  task automatic sample(input logic [11:0] x, input logic [11:0] t, input logic [1:0] h);
    @(negedge clk_sys);
    sample_x = x;
    sample_y = x ^ 12'h5A5;
    sample_z = ~x;
    sample_temp = t;
    sample_hall = h;
    sample_valid = 1'b1;
    @(negedge clk_sys);
    sample_valid = 1'b0;
  endtask

  // One threshold crossing lasting a single cycle, then the level seen a cycle later.
  task automatic pulse_int(input logic exp_after);
    @(negedge clk_sys);
    int_event = 1'b1;
    @(negedge clk_sys);
    chk_flag("int_n_set", 1'b0, int_n_r);
    int_event = 1'b0;
    @(negedge clk_sys);
    chk_flag("int_n_after", exp_after, int_n_r);
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and tests
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // The whole run needs well under 2000 cycles; ten times that means a hang.
  initial
  begin
    #(40 * 20000);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    sample_valid = 1'b0;
    int_event = 1'b0;
    int_hold_en = 1'b0;
    int_record_en = 1'b0;
    sample_x = 12'h000;
    sample_y = 12'h000;
    sample_z = 12'h000;
    sample_temp = 12'h000;
    sample_hall = 2'h0;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      reg_host_model_i.rd(ofs[i], d);
      chk_word("reset_value", 32'h0, d);
    end
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      reg_host_model_i.wr(ofs[i], 32'hFFFF_FFFF, 1'b0);
      reg_host_model_i.rd(ofs[i], d);
      chk_word("user_locked", 32'h0, d);
      reg_host_model_i.wr(ofs[i], 32'hFFFF_FFF0 + 32'(i), 1'b1);
    end
    for (int i = 0; i < 3; i++)
    begin
      reg_host_model_i.rd(ofs[i], d);
      chk_word("user_word", 32'h03FF_FFF0 + 32'(i), d);
    end
    $display("test user_storage done");
    for (int c = 0; c < 8; c++)
    begin
      reg_host_model_i.wr(OFS_CTRL, 32'hFFFF_FF80 | (32'(c) << 4) | (32'(c % 3) << 2), 1'b1);
      reg_host_model_i.rd(OFS_CTRL, d);
      chk_word("control", (32'(c) << 4) | (32'(c % 3) << 2), d);
      chk_word("loop_mode", 32'(c % 3), 32'(loop_mode_r));
    end
    $display("test control done");
    for (int h = 0; h < 3; h++)
    begin
      sample(12'hABC + 12'(h), 12'h5A5 ^ 12'(h), 2'(h));
      reg_host_model_i.rd_pair(hi, lo);
      chk_word("field_hi", hi_exp(12'hABC + 12'(h), 12'h5A5 ^ 12'(h), 1'b1), hi);
      chk_word("field_lo", lo_exp(12'hABC + 12'(h), 12'h5A5 ^ 12'(h), 2'(h)), lo);
      reg_host_model_i.rd(OFS_FIELD_HI, d);
      chk_word("new_cleared", hi_exp(12'hABC + 12'(h), 12'h5A5 ^ 12'(h), 1'b0), d);
    end
    $display("test readout done");
    reg_host_model_i.wr(OFS_CTRL, 32'hFFFF_FFFD, 1'b0);
    reg_host_model_i.rd(OFS_CTRL, d);
    chk_word("mode_locked", 32'h0000_0075, d);
    chk_word("power_mode", {30'h0, MODE_SLEEP}, {30'h0, power_mode_r});
    chk_flag("measure_off", 1'b0, measure_en_r);
    sample(12'h111, 12'h222, 2'h2);
    reg_host_model_i.rd_pair(hi, d);
    chk_word("sleep_hi", hi_exp(12'hABE, 12'h5A7, 1'b0), hi);
    chk_word("sleep_lo", lo_exp(12'hABE, 12'h5A7, 2'h2), d);
    reg_host_model_i.wr(OFS_CTRL, 32'h0, 1'b1);
    $display("test sleep done");
    pulse_int(1'b1);
    int_hold_en = 1'b1;
    pulse_int(1'b0);
    reg_host_model_i.wr(OFS_FIELD_HI, 32'h0000_0000, 1'b1);
    reg_host_model_i.wr(OFS_FIELD_HI, 32'h0000_0040, 1'b0);
    reg_host_model_i.rd(OFS_FIELD_HI, d);
    chk_flag("int_held", 1'b1, d[HI_INT_BIT]);
    reg_host_model_i.wr(OFS_FIELD_HI, 32'h0000_0040, 1'b1);
    reg_host_model_i.rd(OFS_FIELD_HI, d);
    chk_flag("int_cleared", 1'b0, d[HI_INT_BIT]);
    chk_flag("int_n_cleared", 1'b1, int_n_r);
    int_hold_en = 1'b0;
    $display("test interrupt done");
    int_record_en = 1'b1;
    pulse_int(1'b1);
    reg_host_model_i.rd(OFS_FIELD_LO, d);
    chk_flag("record_busy", 1'b1, d[LO_BUSY_BIT]);
    n = 0;
    while (record_done_r !== 1'b1 && n < PROG + 6)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk_flag("record_done", 1'b1, record_done_r);
    reg_host_model_i.rd(OFS_FIELD_LO, d);
    chk_flag("record_idle", 1'b0, d[LO_BUSY_BIT]);
    int_record_en = 1'b0;
    $display("test record done");
    for (int c = 0; c < 3; c++)
    begin
      reg_host_model_i.wr(OFS_CTRL, (32'(c) << 4) | 32'(duty_cycled_power_state), 1'b1);
      repeat (3) @(negedge clk_sys);
      chk_flag("measure_on", 1'b1, measure_en_r);
      sample(12'h321, 12'h0F0, 2'h0);
      repeat (2) @(negedge clk_sys);
      e = int'(INACT_TICKS[c]) * TICKS;
      n = 2;
      while (measure_en_r !== 1'b1 && n < 200)
      begin
        @(negedge clk_sys);
        n++;
      end
      chk_flag("inactive_span", 1'b1, n >= e && n <= e + 4);
    end
    $display("test duty_cycle done");
    clk_en = 1'b0;
    reg_host_model_i.wr(OFS_CTRL, 32'h0000_0001, 1'b1);
    chk_word("frozen_mode", {30'h0, duty_cycled_power_state}, {30'h0, power_mode_r});
    clk_en = 1'b1;
    reg_host_model_i.rd(OFS_CTRL, d);
    chk_word("frozen_ctrl", 32'h0000_0022, d);
    $display("test clock_enable done");
    wrap_up();
  end
endmodule
